// ---- hdl/pss_sram_if.sv ----
// pss_sram_if: synchronous front end of a 256K x 32 pipelined memory
// assumes pins already synchronous to i_ref_clk; oe and sleep are async
//
// Operation
// - register every synchronous input except the mode pin on rising edge
// - load address only on strobe with selects
// - low two address bits seed burst counter
// - burst addresses generated internally under advance
// - burst order linear or interleaved by mode
// - array of 256K 32-bit words
// - writes registered then completed self-timed
// - lane written when its select and gate low
// - all-bytes write covers four lanes, overrides
// - drivers stay enabled one cycle after deselect
// - registered in and out, 3-1-1-1 burst
// - output enable and sleep act asynchronously
// - processor strobe wins over controller strobe
// - read data from previously registered address
// - output enable masked first read after deselect
// - chip selects looked at only on loads
`timescale 1ns/1ps
module pss_sram_if #(
  parameter int AW = pss_pkg::ADDR_W,
  parameter int WORDS = pss_pkg::DEPTH
) (
  input wire logic i_ref_clk, // 250 MHz clock
  input wire logic i_arst_n, // async reset, active low
  input wire logic [AW-1:0] i_addr, // address pins
  input wire logic i_processor_addr_strobe_n, // strobe, low active
  input wire logic i_controller_addr_strobe_n, // strobe, low active
  input wire logic i_burst_advance_n, // advance, low active
  input wire logic i_chip_sel_primary_n, // select, low active
  input wire logic i_chip_sel_high_active, // select, high active
  input wire logic i_chip_sel_third_n, // select, low active
  input wire logic [3:0] i_lane_write_sel_n, // lane selects, low
  input wire logic i_byte_write_gate_n, // byte write gate, low
  input wire logic i_all_bytes_write_n, // all-bytes write, low
  input wire logic i_interleaved_mode, // 1 interleaved, 0 linear
  input wire logic i_out_en_n, // async output enable, low
  input wire logic i_sleep_request, // async sleep, high
  input wire logic [31:0] i_dq, // data pins in
  output logic [31:0] o_dq, // data pins out
  output logic [31:0] o_dq_oe // data pin drive enables
);
  pss_pkg::pss_ctrl_t ctrl_reg;
  logic [AW-1:0] addr_in_reg;
  logic [31:0] din_reg;
  logic [AW-1:0] base_reg;
  logic [1:0] start_reg;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic sel_reg;
  logic sel_next;
  logic load;
  logic is_write;
  logic [3:0] lanes;
  pss_pkg::pss_acc_t acc_reg;
  logic rd_pipe_reg;
  logic drv_reg;
  logic drv_prev_reg;
  logic fresh_reg;
  logic [31:0] rdata;
  logic [31:0] dout_reg;

  function automatic logic [1:0] burst_low(input logic [1:0] start,
                                           input logic [1:0] step,
                                           input logic ilv);
    burst_low = ilv ? (start ^ step) : 2'(start + step);
  endfunction

  // all synchronous pins except the mode pin land in flops before anything looks at them
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_reg <= '{processor_addr_strobe_n: 1'b1,
                    controller_addr_strobe_n: 1'b1,
                    burst_advance_n: 1'b1, chip_sel_primary_n: 1'b1,
                    chip_sel_high_active: 1'b0, chip_sel_third_n: 1'b1,
                    lane_write_sel_n: 4'hf, byte_write_gate_n: 1'b1,
                    all_bytes_write_n: 1'b1};
      addr_in_reg <= '0;
      din_reg <= '0;
    end else begin
      ctrl_reg <= '{i_processor_addr_strobe_n, i_controller_addr_strobe_n,
                    i_burst_advance_n, i_chip_sel_primary_n,
                    i_chip_sel_high_active, i_chip_sel_third_n,
                    i_lane_write_sel_n, i_byte_write_gate_n,
                    i_all_bytes_write_n};
      addr_in_reg <= i_addr;
      din_reg <= i_dq;
    end
  end

  logic sel_ok;
  logic p_strobe;
  logic c_strobe;
  always_comb begin
    sel_ok = !ctrl_reg.chip_sel_primary_n && ctrl_reg.chip_sel_high_active
             && !ctrl_reg.chip_sel_third_n;
    // processor strobe is dropped when the primary select is high
    p_strobe = !ctrl_reg.processor_addr_strobe_n
               && !ctrl_reg.chip_sel_primary_n;
    // processor strobe wins, so the controller one counts only alone
    c_strobe = ctrl_reg.processor_addr_strobe_n
               && !ctrl_reg.controller_addr_strobe_n;
    load = p_strobe || c_strobe;
  end

  // selects matter only on a load; otherwise selection state is held
  always_comb begin
    sel_next = sel_reg;
    cnt_next = cnt_reg;
    if (load) begin
      sel_next = sel_ok;
      cnt_next = 2'h0;
    end else if (!ctrl_reg.burst_advance_n) begin
      cnt_next = 2'(cnt_reg + 2'h1);
    end
    // advance high: count stays, same location is accessed again
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sel_reg <= 1'b0;
      cnt_reg <= pss_pkg::BURST_RST;
      base_reg <= '0;
      start_reg <= pss_pkg::BURST_RST;
    end else begin
      sel_reg <= sel_next;
      cnt_reg <= cnt_next;
      if (load && sel_ok) begin
        base_reg <= addr_in_reg;
        start_reg <= addr_in_reg[1:0];
      end
    end
  end

  // write decode; the all-bytes write overrides lanes and gate
  always_comb begin
    if (!ctrl_reg.all_bytes_write_n) begin
      lanes = 4'hf;
    end else if (!ctrl_reg.byte_write_gate_n) begin
      lanes = ~ctrl_reg.lane_write_sel_n;
    end else begin
      lanes = 4'h0;
    end
    // a processor-strobe load always starts as a read
    is_write = (lanes != 4'h0) && !p_strobe;
  end

  logic [AW-1:0] cur_addr;
  always_comb begin
    cur_addr = load ? addr_in_reg
             : {base_reg[AW-1:2],
                burst_low(start_reg, cnt_next, i_interleaved_mode)};
  end

  // access is issued one edge after capture: stage 2 of the pipeline
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc_reg <= '0;
    end else begin
      acc_reg.en <= sel_next;
      acc_reg.wr <= is_write;
      acc_reg.lanes <= lanes;
      acc_reg.addr <= cur_addr;
      acc_reg.wdata <= din_reg;
    end
  end

  // sleep reaches the pin drivers directly, but the clocked array enable
  // only sees it after two flops so a late sleep edge cannot go metastable
  logic sleep_meta_reg;
  logic sleep_sync_reg;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sleep_meta_reg <= 1'b0;
      sleep_sync_reg <= 1'b0;
    end else begin
      sleep_meta_reg <= i_sleep_request;
      sleep_sync_reg <= sleep_meta_reg;
    end
  end

  pss_array #(
    .AW(AW),
    .WORDS(WORDS)
  ) u_array (
    .i_ref_clk(i_ref_clk),
    .i_en(acc_reg.en && !sleep_sync_reg),
    .i_wr(acc_reg.wr),
    .i_lanes(acc_reg.lanes),
    .i_addr(acc_reg.addr),
    .i_wdata(acc_reg.wdata),
    .o_rdata(rdata)
  );

  // output register gives 3 cycles to first word, 1 after
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_pipe_reg <= 1'b0;
      dout_reg <= '0;
    end else begin
      rd_pipe_reg <= acc_reg.en && !acc_reg.wr;
      if (rd_pipe_reg) begin
        dout_reg <= rdata;
      end
    end
  end

  // extra enable stage keeps drivers on one more cycle after deselect
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      drv_reg <= 1'b0;
      drv_prev_reg <= 1'b0;
      fresh_reg <= 1'b0;
    end else begin
      drv_reg <= rd_pipe_reg;
      drv_prev_reg <= drv_reg;
      // first read clock after a deselected stretch masks output enable
      fresh_reg <= rd_pipe_reg && !drv_reg && !drv_prev_reg;
    end
  end

  // output enable and sleep are not clocked: they gate drivers directly
  always_comb begin
    o_dq = dout_reg;
    o_dq_oe = (!i_out_en_n && !i_sleep_request && !fresh_reg
               && (drv_reg || drv_prev_reg)) ? 32'hffffffff : 32'h0;
  end
endmodule

// ---- hdl/pss_pkg.sv ----
// pss_pkg: shared types and constants for the pipelined sync memory block
// assumes one 250 MHz clock; no software-visible registers
package pss_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int DEPTH = 262144;
  localparam logic [1:0] BURST_RST = 2'h0;
  localparam int CLK_PERIOD_PS = 4000;

  // registered synchronous controls, all active-low as on the pins
  // except the high-active chip select
  typedef struct packed {
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_advance_n;
    logic chip_sel_primary_n;
    logic chip_sel_high_active;
    logic chip_sel_third_n;
    logic [3:0] lane_write_sel_n;
    logic byte_write_gate_n;
    logic all_bytes_write_n;
  } pss_ctrl_t;

  // one array access as the core sees it
  typedef struct packed {
    logic en;
    logic wr;
    logic [3:0] lanes;
    logic [17:0] addr;
    logic [31:0] wdata;
  } pss_acc_t;
endpackage

// ---- hdl/pss_array.sv ----
// pss_array: byte-lane writable storage with a registered read port
// assumes accesses arrive already registered from pss_sram_if
`timescale 1ns/1ps
module pss_array #(
  parameter int AW = 18,
  parameter int WORDS = 262144
) (
  input wire logic i_ref_clk, // core clock
  input wire logic i_en, // access this cycle
  input wire logic i_wr, // write when high
  input wire logic [3:0] i_lanes, // byte lanes to write
  input wire logic [AW-1:0] i_addr, // word index
  input wire logic [31:0] i_wdata, // write data
  output logic [31:0] o_rdata // read data, one cycle later
);
  logic [31:0] mem_reg [WORDS];

  // self-timed write: a whole write completes at this single edge
  always_ff @(posedge i_ref_clk) begin
    if (i_en && i_wr) begin
      for (int l = 0; l < 4; l++) begin
        if (i_lanes[l]) begin
          mem_reg[i_addr][8*l +: 8] <= i_wdata[8*l +: 8];
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_en && !i_wr) begin
      o_rdata <= mem_reg[i_addr];
    end
  end
endmodule

// ---- verif/pss_sram_if_props.sv ----
// pss_sram_if_props: pin-level timing checks of the memory front end
// bound into pss_sram_if; sees its ports only
`timescale 1ns/1ps
module pss_sram_if_props (
  input wire logic i_ref_clk, // clk
  input wire logic i_arst_n, // rst
  input wire logic i_processor_addr_strobe_n, // in
  input wire logic i_controller_addr_strobe_n, // in
  input wire logic i_burst_advance_n, // in
  input wire logic i_chip_sel_primary_n, // in
  input wire logic i_chip_sel_high_active, // in
  input wire logic i_chip_sel_third_n, // in
  input wire logic i_byte_write_gate_n, // in
  input wire logic i_all_bytes_write_n, // in
  input wire logic i_out_en_n, // in
  input wire logic i_sleep_request, // in
  input wire logic [31:0] o_dq, // out
  input wire logic [31:0] o_dq_oe // out
);
  logic nold, rd_ld, desel, quiet;
  assign nold = i_processor_addr_strobe_n && i_controller_addr_strobe_n;
  assign rd_ld = !i_processor_addr_strobe_n && !i_chip_sel_primary_n &&
    i_chip_sel_high_active && !i_chip_sel_third_n;
  assign desel = i_processor_addr_strobe_n && !i_controller_addr_strobe_n &&
    !i_chip_sel_high_active;
  assign quiet = nold && i_burst_advance_n && i_byte_write_gate_n &&
    i_all_bytes_write_n && !i_sleep_request;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  property p_sleep; i_sleep_request |-> o_dq_oe == 32'h0; endproperty
  a_sleep: assert property (p_sleep) else $error("drive in sleep");
  property p_oe; i_out_en_n |-> o_dq_oe == 32'h0; endproperty
  a_oe: assert property (p_oe) else $error("drive with oe off");
  property p_rd_on; rd_ld ##1 quiet [*5] |-> o_dq_oe == 32'hffffffff ||
    i_out_en_n; endproperty
  a_rd_on: assert property (p_rd_on) else $error("no drive");
  property p_rst; $rose(i_arst_n) |-> o_dq == 32'h0 && o_dq_oe == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("busy after reset");
  property p_hold; quiet [*6] |-> $stable(o_dq); endproperty
  a_hold: assert property (p_hold) else $error("held word moved");
  property p_dcd_on; o_dq_oe != 32'h0 && desel && !i_out_en_n |=>
    o_dq_oe != 32'h0 || i_out_en_n || i_sleep_request; endproperty
  a_dcd_on: assert property (p_dcd_on) else $error("early off");
  property p_dcd_off; desel ##1 nold [*5] |-> o_dq_oe == 32'h0; endproperty
  a_dcd_off: assert property (p_dcd_off) else $error("late off");
  property p_mask; desel ##1 nold [*5] ##1 rd_ld |-> ##4 o_dq_oe == 32'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("oe not masked");
endmodule

// ---- verif/pss_host_model.sv ----
// pss_host_model: bus master driving the memory's synchronous pins
// assumes the bench calls one task per bus cycle
`timescale 1ns/1ps
module pss_host_model (
  input wire logic i_ref_clk, // clk
  output pss_pkg::pss_ctrl_t o_ctl, // sync controls
  output logic [17:0] o_addr, // address
  output logic [31:0] o_dq // write data
);
  localparam logic [11:0] IDLE = 12'hebf;
  initial begin
    o_ctl = IDLE;
    o_addr = 18'h0;
    o_dq = 32'h0;
  end
  // change just after the edge, hold to the next; a released data bus
  // toggles so a stale word can never pass for written data
  task automatic put(input logic [11:0] c, input logic [17:0] a,
    input logic [31:0] d);
    @(posedge i_ref_clk);
    #1;
    o_ctl = c;
    o_addr = a;
    o_dq = (c[1:0] != 2'b11) ? d : ~o_dq;
  endtask
  task automatic idle(); put(IDLE, ~o_addr, 32'h0); endtask
  task automatic rd(input logic [17:0] a); put(12'h6bf, a, 32'h0); endtask
  task automatic burst_advance(); put(12'hcbf, ~o_addr, 32'h0); endtask
  task automatic desel(); put(12'ha3f, ~o_addr, 32'h0); endtask
  task automatic wr(input logic [17:0] a, input logic [31:0] d,
    input logic [3:0] ln_n, input logic g_n, input logic a_n);
    put({6'h2a, ln_n, g_n, a_n}, a, d);
  endtask
endmodule

// ---- verif/pss_sram_if_bench.sv ----
// pss_sram_if_bench: directed tests of the memory front end
// assumes pss_pkg, the design, the host model and the checker compiled
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  fail_count++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module pss_sram_if_bench;
  logic clk, arst_n, ilv, oe_n, sleep;
  pss_pkg::pss_ctrl_t ctl;
  logic [17:0] addr;
  logic [31:0] h_dq, o_dq, o_dq_oe, dq_w;
  logic [31:0] mem [4];
  int fail_count, check_count;
  localparam logic [17:0] BASE = 18'h3fffc;
  assign dq_w = (o_dq & o_dq_oe) | (h_dq & ~o_dq_oe);
  pss_host_model u_pss_host_model (.i_ref_clk(clk), .o_ctl(ctl),
    .o_addr(addr), .o_dq(h_dq));
  pss_sram_if u_pss_sram_if (.i_ref_clk(clk), .i_arst_n(arst_n),
    .i_addr(addr), .i_processor_addr_strobe_n(ctl.processor_addr_strobe_n),
    .i_controller_addr_strobe_n(ctl.controller_addr_strobe_n),
    .i_burst_advance_n(ctl.burst_advance_n),
    .i_chip_sel_primary_n(ctl.chip_sel_primary_n),
    .i_chip_sel_high_active(ctl.chip_sel_high_active),
    .i_chip_sel_third_n(ctl.chip_sel_third_n),
    .i_lane_write_sel_n(ctl.lane_write_sel_n),
    .i_byte_write_gate_n(ctl.byte_write_gate_n),
    .i_all_bytes_write_n(ctl.all_bytes_write_n), .i_interleaved_mode(ilv),
    .i_out_en_n(oe_n), .i_sleep_request(sleep), .i_dq(dq_w), .o_dq(o_dq),
    .o_dq_oe(o_dq_oe));
  task automatic burst(input logic [1:0] s);
    logic [1:0] k;
    u_pss_host_model.rd(BASE | 18'(s));
    repeat (3) u_pss_host_model.burst_advance();
    u_pss_host_model.idle();
    for (int j = 0; j < 4; j++) begin
      k = ilv ? s ^ 2'(j) : s + 2'(j);
      `CHK("burst word", mem[k], o_dq)
      u_pss_host_model.idle();
    end
  endtask
  task automatic t_write();
    for (int j = 0; j < 4; j++) begin
      mem[j] = 32'h5a5a0000 + j;
      u_pss_host_model.wr(BASE | 18'(j), mem[j], 4'hf, 1'b1, 1'b0);
    end
    u_pss_host_model.wr(BASE, 32'hffffffff, 4'ha, 1'b0, 1'b1);
    mem[0] = (mem[0] & 32'hff00ff00) | 32'h00ff00ff;
    u_pss_host_model.wr(BASE | 18'h1, 32'h0, 4'h0, 1'b1, 1'b1);
    // processor-strobe load, then the write follows on the next cycle
    u_pss_host_model.rd(BASE | 18'h1);
    u_pss_host_model.put(12'hebe, BASE, 32'hc3c3a5a5);
    mem[1] = 32'hc3c3a5a5;
    burst(2'h0);
    $display("t_write done");
  endtask
  task automatic t_modes();
    burst(2'h3);
    ilv = 1'b1;
    burst(2'h1);
    ilv = 1'b0;
    $display("t_modes done");
  endtask
  task automatic t_ignore();
    u_pss_host_model.rd(BASE | 18'h2);
    u_pss_host_model.put(12'h7bf, BASE | 18'h3, 32'h0);
    repeat (5) u_pss_host_model.idle();
    `CHK("ignored strobe", mem[2], o_dq)
    `CHK("ignored selects", 32'hffffffff, o_dq_oe)
    u_pss_host_model.put(12'h2be, BASE | 18'h3, 32'h0);
    repeat (5) u_pss_host_model.idle();
    `CHK("both strobes", mem[3], o_dq)
    $display("t_ignore done");
  endtask
  task automatic t_oe();
    u_pss_host_model.rd(BASE);
    repeat (4) u_pss_host_model.idle();
    `CHK("drive on", 32'hffffffff, o_dq_oe)
    oe_n = 1'b1;
    u_pss_host_model.idle();
    `CHK("oe off", 32'h0, o_dq_oe)
    oe_n = 1'b0;
    sleep = 1'b1;
    u_pss_host_model.idle();
    `CHK("sleep off", 32'h0, o_dq_oe)
    sleep = 1'b0;
    u_pss_host_model.desel();
    repeat (5) u_pss_host_model.idle();
    `CHK("deselected", 32'h0, o_dq_oe)
    u_pss_host_model.rd(BASE);
    repeat (4) u_pss_host_model.idle();
    `CHK("first masked", 32'h0, o_dq_oe)
    u_pss_host_model.idle();
    `CHK("then driven", 32'hffffffff, o_dq_oe)
    `CHK("read word", mem[0], o_dq)
    $display("t_oe done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // tests need about 80 cycles; this leaves ample margin
  initial begin
    #20000;
    fail_count++;
    wrap_up();
  end
  initial begin
    arst_n = 1'b0;
    ilv = 1'b0;
    oe_n = 1'b0;
    sleep = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    arst_n = 1'b1;
    u_pss_host_model.idle();
    t_write();
    t_modes();
    t_ignore();
    t_oe();
    repeat (8) u_pss_host_model.idle();
    wrap_up();
  end
endmodule
bind pss_sram_if pss_sram_if_props u_pss_sram_if_props (.i_ref_clk,
  .i_arst_n, .i_processor_addr_strobe_n, .i_controller_addr_strobe_n,
  .i_burst_advance_n, .i_chip_sel_primary_n, .i_chip_sel_high_active,
  .i_chip_sel_third_n, .i_byte_write_gate_n, .i_all_bytes_write_n,
  .i_out_en_n, .i_sleep_request, .o_dq, .o_dq_oe);
